// ### src/serial_pkg.sv
// shared constants and types for the serial datapath
package serial_pkg;

  // register offsets on the plain port
  localparam logic [2:0] ADDR_DATA  = 3'h0;
  localparam logic [2:0] ADDR_CSA   = 3'h1;
  localparam logic [2:0] ADDR_CSB   = 3'h2;
  localparam logic [2:0] ADDR_CSC   = 3'h3;
  localparam logic [2:0] ADDR_BAUD  = 3'h4;

  // control_status_a bit positions
  localparam int CSA_RX_PENDING  = 7;
  localparam int CSA_TX_DONE     = 6;
  localparam int CSA_TX_EMPTY    = 5;
  localparam int CSA_STOP_ERR    = 4;
  localparam int CSA_OVERRUN     = 3;
  localparam int CSA_PARITY_ERR  = 2;

  // control_status_b bit positions
  localparam int CSB_EMPTY_IE    = 5;
  localparam int CSB_DONE_IE     = 6;
  localparam int CSB_RX_EN       = 4;
  localparam int CSB_TX_EN       = 3;
  localparam int CSB_SIZE2       = 2;
  localparam int CSB_RX_NINTH    = 1;
  localparam int CSB_TX_NINTH    = 0;

  // control_status_c bit positions
  localparam int CSC_SYNC        = 6;
  localparam int CSC_PAR_EN      = 5;
  localparam int CSC_PAR_ODD     = 4;
  localparam int CSC_TWO_STOP    = 3;
  localparam int CSC_SIZE_HI     = 2;
  localparam int CSC_SIZE_LO     = 1;

  // reset values
  localparam logic [7:0] CSB_RESET  = 8'h00;
  localparam logic [7:0] CSC_RESET  = 8'h06;
  localparam logic [7:0] BAUD_RESET = 8'h00;

  localparam logic [2:0] SIZE_NINE  = 3'h7;
  localparam int         RX_DEPTH   = 2;

  // frame format shared by both directions
  typedef struct packed {
    logic       par_en;
    logic       par_odd;
    logic       two_stop;
    logic [3:0] nbits;
  } frame_cfg_s;

  // one receive fifo entry
  typedef struct packed {
    logic       stop_err;
    logic       overrun;
    logic       par_err;
    logic [8:0] data;
  } rx_entry_s;

endpackage

// ### src/serial_tx_shift.sv
// transmit shift register: start, data lsb first, parity, stops
`timescale 1ns/1ps
module serial_tx_shift
  import serial_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       bit_tick,
  input  frame_cfg_s      cfg,
  input  wire logic       load,
  input  wire logic [8:0] load_data,
  output logic            busy,
  output logic            frame_end,
  output logic            txd
);

  typedef enum logic [4:0] {
    S_IDLE   = 5'b00001,
    S_START  = 5'b00010,
    S_DATA   = 5'b00100,
    S_PARITY = 5'b01000,
    S_STOP   = 5'b10000
  } tx_state_e;

  tx_state_e  state_q;
  logic [8:0] shift_q;
  logic [3:0] cnt_q;
  logic       par_q;
  logic       txd_q;

  assign busy      = (state_q != S_IDLE);
  assign txd       = txd_q;
  assign frame_end = bit_tick && (state_q == S_STOP) &&
                     (cnt_q == 4'h0);

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      state_q <= S_IDLE;
      shift_q <= 9'h000;
      cnt_q   <= 4'h0;
      par_q   <= 1'b0;
      txd_q   <= 1'b1;
    end
    else if (load)
    begin
      // start bit waits for a tick boundary so it lasts a full bit
      state_q <= bit_tick ? S_DATA : S_START;
      shift_q <= load_data;
      cnt_q   <= cfg.nbits;
      par_q   <= cfg.par_odd;
      txd_q   <= !bit_tick;
    end
    else if (bit_tick)
    begin
      case (state_q)
        S_IDLE:
        begin
          txd_q <= 1'b1;
        end
        S_START:
        begin
          txd_q   <= 1'b0;
          state_q <= S_DATA;
        end
        S_DATA:
        begin
          txd_q   <= shift_q[0];
          par_q   <= par_q ^ shift_q[0];
          shift_q <= {1'b0, shift_q[8:1]};
          cnt_q   <= cnt_q - 4'h1;
          if (cnt_q == 4'h1)
          begin
            state_q <= cfg.par_en ? S_PARITY : S_STOP;
            cnt_q   <= cfg.two_stop ? 4'h2 : 4'h1;
          end
        end
        S_PARITY:
        begin
          txd_q   <= par_q;
          state_q <= S_STOP;
        end
        S_STOP:
        begin
          txd_q <= 1'b1;
          if (cnt_q == 4'h0)
          begin
            state_q <= S_IDLE;
          end
          else
          begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        default:
        begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

endmodule // serial_tx_shift

// ### src/serial_rx_shift.sv
// receive shift register: start detect, sampling, first stop check
`timescale 1ns/1ps
module serial_rx_shift
  import serial_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       enable,
  input  wire logic       sample_tick,
  input  wire logic       half_tick,
  input  frame_cfg_s      cfg,
  input  wire logic       rxd,
  output logic            start_seen,
  output logic            done,
  output rx_entry_s       entry
);

  typedef enum logic [4:0] {
    S_IDLE   = 5'b00001,
    S_START  = 5'b00010,
    S_DATA   = 5'b00100,
    S_PARITY = 5'b01000,
    S_STOP   = 5'b10000
  } rx_state_e;

  rx_state_e  state_q;
  logic [8:0] shift_q;
  logic [3:0] cnt_q;
  logic       par_q;
  logic       done_q;
  rx_entry_s  entry_q;

  assign start_seen = (state_q == S_IDLE) && enable && !rxd;
  assign done       = done_q;
  assign entry      = entry_q;

  always_ff @(posedge clk)
  begin
    if (!reset_n || !enable)
    begin
      state_q <= S_IDLE;
      shift_q <= 9'h000;
      cnt_q   <= 4'h0;
      par_q   <= 1'b0;
      done_q  <= 1'b0;
      entry_q <= '0;
    end
    else
    begin
      done_q <= 1'b0;
      case (state_q)
        S_IDLE:
        begin
          if (!rxd)
          begin
            state_q <= S_START;
          end
        end
        S_START:
        begin
          // mid-bit recheck rejects glitches as false starts
          if (half_tick)
          begin
            state_q <= rxd ? S_IDLE : S_DATA;
            cnt_q   <= cfg.nbits;
            par_q   <= cfg.par_odd;
            shift_q <= 9'h000;
          end
        end
        S_DATA:
        begin
          if (sample_tick)
          begin
            shift_q <= {rxd, shift_q[8:1]};
            par_q   <= par_q ^ rxd;
            cnt_q   <= cnt_q - 4'h1;
            if (cnt_q == 4'h1)
            begin
              state_q <= cfg.par_en ? S_PARITY : S_STOP;
            end
          end
        end
        S_PARITY:
        begin
          if (sample_tick)
          begin
            par_q   <= par_q ^ rxd;
            state_q <= S_STOP;
          end
        end
        S_STOP:
        begin
          // only the first stop bit is looked at
          if (sample_tick)
          begin
            state_q          <= S_IDLE;
            done_q           <= 1'b1;
            entry_q.stop_err <= !rxd;
            entry_q.par_err  <= cfg.par_en && par_q;
            entry_q.overrun  <= 1'b0;
            // right-align so unused upper bits read zero
            entry_q.data     <= shift_q >> (4'h9 - cfg.nbits);
          end
        end
        default:
        begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

endmodule // serial_rx_shift

// ### src/serial_datapath.sv
// serial port transmit and receive datapath with register port
//
// The strobed register port and the address map were left to the implementer.
`timescale 1ns/1ps
module serial_datapath
  import serial_pkg::*;
#(
  parameter int DEPTH = RX_DEPTH
)
(
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  output logic [7:0]      reg_rdata,
  input  wire logic       tx_done_irq_ack,
  output logic            tx_empty_irq,
  output logic            tx_done_irq,
  input  wire logic       rxd_pin,
  input  wire logic       xck_pin,
  output logic            txd_out,
  output logic            txd_oe,
  output logic            rxd_owned
);

  localparam int PW = $clog2(DEPTH);

  logic [7:0] csb_q;
  logic [7:0] csc_q;
  logic [7:0] baud_q;
  logic [8:0] tx_buf_q;
  logic       tx_buffer_empty_flag;
  logic       tx_done_flag;
  logic       tx_active_q;
  logic [7:0] rdata_q;
  logic [7:0] div_q;
  logic [3:0] os_q;
  logic [1:0] rxd_sync_q;
  logic [2:0] xck_sync_q;
  logic       tx_busy;
  logic       tx_frame_end;
  logic       tx_load;
  logic       txd_raw;
  logic       rx_start;
  logic       rx_done;
  rx_entry_s  rx_new;
  rx_entry_s  fifo_q [DEPTH];
  logic [PW:0] count_q;
  logic [PW-1:0] rd_q;
  logic [PW-1:0] wr_q;
  logic       overrun_pend_q;
  logic       bit_tick;
  logic       rx_tick;
  logic [3:0] rx_os_q;
  logic       rx_sample;
  logic       rx_half;
  logic       xck_rise;
  logic       sync_mode;
  logic       data_read;
  logic       rx_enable_bit;
  logic       tx_enable_bit;
  rx_entry_s  head;
  frame_cfg_s cfg;

  assign sync_mode     = csc_q[CSC_SYNC];
  assign rx_enable_bit = csb_q[CSB_RX_EN];
  assign tx_enable_bit = csb_q[CSB_TX_EN];
  assign cfg.par_en    = csc_q[CSC_PAR_EN];
  assign cfg.par_odd   = csc_q[CSC_PAR_ODD];
  assign cfg.two_stop  = csc_q[CSC_TWO_STOP];
  assign cfg.nbits     = (({csb_q[CSB_SIZE2], csc_q[CSC_SIZE_HI],
                            csc_q[CSC_SIZE_LO]}) == SIZE_NINE) ? 4'h9 :
                         4'h5 + {2'b00, csc_q[CSC_SIZE_HI],
                                 csc_q[CSC_SIZE_LO]};
  assign data_read     = reg_read && (reg_addr == ADDR_DATA);
  assign head          = fifo_q[rd_q];

  // two-flop synchronisers for the pins
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      rxd_sync_q <= 2'b11;
      xck_sync_q <= 3'b000;
    end
    else
    begin
      rxd_sync_q <= {rxd_sync_q[0], rxd_pin};
      xck_sync_q <= {xck_sync_q[1:0], xck_pin};
    end
  end

  // edge taken between second and third stage, never the first
  assign xck_rise = xck_sync_q[1] && !xck_sync_q[2];

  // internal baud: divider then 16x oversample
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      div_q <= 8'h00;
      os_q  <= 4'h0;
    end
    else if (div_q == baud_q)
    begin
      div_q <= 8'h00;
      os_q  <= os_q + 4'h1;
    end
    else
    begin
      div_q <= div_q + 8'h01;
    end
  end

  assign bit_tick  = sync_mode ? xck_rise :
                     ((div_q == baud_q) && (os_q == 4'hf));

  // receive phase restarts at each start edge so samples land mid-bit
  always_ff @(posedge clk)
  begin
    if (!reset_n || rx_start)
    begin
      rx_os_q <= 4'h0;
    end
    else if (div_q == baud_q)
    begin
      rx_os_q <= rx_os_q + 4'h1;
    end
  end

  assign rx_tick   = (div_q == baud_q) && (rx_os_q == 4'h7);
  assign rx_sample = sync_mode ? xck_rise : rx_tick;
  assign rx_half   = sync_mode ? xck_rise : rx_tick;

  // control registers
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      csb_q  <= CSB_RESET;
      csc_q  <= CSC_RESET;
      baud_q <= BAUD_RESET;
    end
    else if (reg_write)
    begin
      case (reg_addr)
        ADDR_CSB:  csb_q  <= {reg_wdata[7:2], csb_q[CSB_RX_NINTH],
                              reg_wdata[0]};
        ADDR_CSC:  csc_q  <= reg_wdata;
        ADDR_BAUD: baud_q <= reg_wdata;
        default:   csb_q  <= csb_q;
      endcase
    end
  end

  // transmit buffer and empty flag
  assign tx_load = !tx_buffer_empty_flag && tx_active_q &&
                   (!tx_busy || tx_frame_end);

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      tx_buf_q             <= 9'h000;
      tx_buffer_empty_flag <= 1'b1;
    end
    else if (reg_write && (reg_addr == ADDR_DATA) && tx_enable_bit)
    begin
      tx_buf_q             <= {csb_q[CSB_TX_NINTH], reg_wdata};
      tx_buffer_empty_flag <= 1'b0;
    end
    else if (tx_load)
    begin
      tx_buffer_empty_flag <= 1'b1;
    end
  end

  // done flag: set beats either kind of clear
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      tx_done_flag <= 1'b0;
    end
    else if (tx_frame_end && tx_buffer_empty_flag)
    begin
      tx_done_flag <= 1'b1;
    end
    else if (tx_done_irq_ack ||
             (reg_write && (reg_addr == ADDR_CSA) &&
              reg_wdata[CSA_TX_DONE]))
    begin
      tx_done_flag <= 1'b0;
    end
  end

  // transmitter stays on until shifter and buffer are both drained
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      tx_active_q <= 1'b0;
    end
    else if (tx_enable_bit)
    begin
      tx_active_q <= 1'b1;
    end
    else if (!tx_busy && tx_buffer_empty_flag)
    begin
      tx_active_q <= 1'b0;
    end
  end

  assign tx_empty_irq = csb_q[CSB_EMPTY_IE] && tx_buffer_empty_flag;
  assign tx_done_irq  = csb_q[CSB_DONE_IE] && tx_done_flag;
  assign txd_out      = txd_raw;
  assign txd_oe       = tx_active_q;
  assign rxd_owned    = rx_enable_bit;

  serial_tx_shift u_tx (
    .clk       (clk),
    .reset_n   (reset_n),
    .bit_tick  (bit_tick),
    .cfg       (cfg),
    .load      (tx_load),
    .load_data (tx_buf_q),
    .busy      (tx_busy),
    .frame_end (tx_frame_end),
    .txd       (txd_raw)
  );

  serial_rx_shift u_rx (
    .clk         (clk),
    .reset_n     (reset_n),
    .enable      (rx_enable_bit),
    .sample_tick (rx_sample),
    .half_tick   (rx_half),
    .cfg         (cfg),
    .rxd         (rxd_sync_q[1]),
    .start_seen  (rx_start),
    .done        (rx_done),
    .entry       (rx_new)
  );

  // overrun: fifo full and a new start arrives
  always_ff @(posedge clk)
  begin
    if (!reset_n || !rx_enable_bit)
    begin
      overrun_pend_q <= 1'b0;
    end
    else if (rx_start && (count_q == (PW+1)'(DEPTH)))
    begin
      overrun_pend_q <= 1'b1;
    end
    else if (rx_done && (count_q != (PW+1)'(DEPTH)))
    begin
      overrun_pend_q <= 1'b0;
    end
  end

  // receive fifo with flags per entry; flushed on disable
  always_ff @(posedge clk)
  begin
    if (!reset_n || !rx_enable_bit)
    begin
      count_q <= '0;
      rd_q    <= '0;
      wr_q    <= '0;
    end
    else
    begin
      if (rx_done && (count_q != (PW+1)'(DEPTH)))
      begin
        wr_q <= (wr_q == PW'(DEPTH-1)) ? '0 : wr_q + PW'(1);
      end
      if (data_read && (count_q != '0))
      begin
        rd_q <= (rd_q == PW'(DEPTH-1)) ? '0 : rd_q + PW'(1);
      end
      count_q <= count_q
               + (PW+1)'(rx_done && (count_q != (PW+1)'(DEPTH)))
               - (PW+1)'(data_read && (count_q != '0));
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++)
    begin : g_fifo
      always_ff @(posedge clk)
      begin
        if (!reset_n)
        begin
          fifo_q[gi] <= '0;
        end
        else if (rx_done && (wr_q == PW'(gi)) &&
                 (count_q != (PW+1)'(DEPTH)))
        begin
          fifo_q[gi]         <= rx_new;
          fifo_q[gi].overrun <= overrun_pend_q;
        end
      end
    end
  endgenerate

  // read data one cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      rdata_q <= 8'h00;
    end
    else if (reg_read)
    begin
      case (reg_addr)
        ADDR_DATA: rdata_q <= (count_q != '0) ? head.data[7:0]
                                              : 8'h00;
        ADDR_CSA:  rdata_q <= {count_q != '0, tx_done_flag,
                               tx_buffer_empty_flag,
                               head.stop_err, head.overrun,
                               head.par_err, 2'b00};
        // ninth bit marks address frames in multiprocessor use
        ADDR_CSB:  rdata_q <= {csb_q[7:2], head.data[8],
                               csb_q[CSB_TX_NINTH]};
        ADDR_CSC:  rdata_q <= csc_q;
        ADDR_BAUD: rdata_q <= baud_q;
        default:   rdata_q <= 8'h00;
      endcase
    end
  end

  assign reg_rdata = rdata_q;

endmodule // serial_datapath

// ### testbench/serial_datapath_asserts.sv
// port-level assertion checker for the serial datapath
`timescale 1ns/1ps
module serial_datapath_asserts
  import serial_pkg::*;
#(
  parameter int DEPTH = RX_DEPTH
)
(
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_write,
  input wire logic       reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic       tx_done_irq_ack,
  input wire logic       tx_empty_irq,
  input wire logic       tx_done_irq,
  input wire logic       rxd_pin,
  input wire logic       xck_pin,
  input wire logic       txd_out,
  input wire logic       txd_oe,
  input wire logic       rxd_owned
);
  logic [7:0] csb_q;
  logic       wr_csb;
  assign wr_csb = reg_write && reg_addr == ADDR_CSB;
  // shadow of the enable bits, updated on the same edge as the design
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      csb_q <= CSB_RESET;
    else if (wr_csb)
      csb_q <= reg_wdata;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // baud divider left at zero: sixteen clocks a bit
  sequence low_bit;
    !txd_out [*8] ##1 !txd_out [*8];
  endsequence
  sequence data_write;
    reg_write && reg_addr == ADDR_DATA;
  endsequence
  chk_empty_clear: assert property (
    data_write ##0 (tx_empty_irq && csb_q[CSB_TX_EN]) |=> !tx_empty_irq)
    else $error("empty request stayed after data write");
  chk_empty_gate: assert property (
    !csb_q[CSB_EMPTY_IE] |-> !tx_empty_irq)
    else $error("empty request while disabled");
  chk_done_gate: assert property (
    !csb_q[CSB_DONE_IE] |-> !tx_done_irq)
    else $error("done request while disabled");
  chk_done_ack: assert property (
    tx_done_irq_ack && tx_done_irq |=> !tx_done_irq)
    else $error("done request survived service");
  chk_done_w1c: assert property (
    reg_write && reg_addr == ADDR_CSA && reg_wdata[CSA_TX_DONE]
    && tx_done_irq |=> !tx_done_irq)
    else $error("done request survived write one");
  chk_bit_width: assert property (
    $fell(txd_out) |-> low_bit)
    else $error("low bit shorter than one bit period");
  chk_idle_high: assert property (
    !txd_oe |-> txd_out)
    else $error("released output not idle high");
  chk_oe_start: assert property (
    $rose(txd_oe) |-> csb_q[CSB_TX_EN])
    else $error("output taken while transmitter off");
  chk_oe_drain: assert property (
    $fell(txd_oe) |-> !csb_q[CSB_TX_EN] && $past(txd_out, 16))
    else $error("output released before frame end");
  chk_rx_owner: assert property (
    wr_csb |=> rxd_owned == $past(reg_wdata[CSB_RX_EN]))
    else $error("receiver ownership not following enable");
  chk_done_idle: assert property (
    $rose(tx_done_irq) |-> txd_out && $past(txd_out, 8))
    else $error("done raised before stop bit ended");
endmodule // serial_datapath_asserts

bind serial_datapath serial_datapath_asserts #(.DEPTH(DEPTH)) chk_u (
  .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .tx_done_irq_ack(tx_done_irq_ack),
  .tx_empty_irq(tx_empty_irq), .tx_done_irq(tx_done_irq),
  .rxd_pin(rxd_pin), .xck_pin(xck_pin), .txd_out(txd_out),
  .txd_oe(txd_oe), .rxd_owned(rxd_owned));

// ### testbench/serial_node_model.sv
// remote serial node: sends frames, captures frames off the line
`timescale 1ns/1ps
module serial_node_model
#(
  parameter int BIT_CLKS = 16
)
(
  input  wire logic       clk,
  input  wire logic       line_in,
  input  wire logic [3:0] cap_len,
  output logic            sync_transfer_clock,
  output logic            line_out
);
  logic [11:0] got;
  int          got_cnt;
  initial
  begin
    line_out = 1'b1;
    sync_transfer_clock      = 1'b0;
    got      = '1;
    got_cnt  = 0;
  end
  // bits holds data, parity and stops in line order
  task automatic send(input logic [11:0] bits, input int len);
    int i;
    @(posedge clk);
    line_out <= 1'b0;
    // transfer clock rises mid-bit, rests low outside frames
    for (i = 0; i <= len; i++)
    begin
      repeat (BIT_CLKS / 2) @(posedge clk);
      sync_transfer_clock <= 1'b1;
      repeat (BIT_CLKS / 2) @(posedge clk);
      sync_transfer_clock      <= 1'b0;
      line_out <= (i == len) ? 1'b1 : bits[i];
    end
  endtask
  // samples mid-bit; unsampled positions read high like the idle line
  always
  begin
    @(posedge clk);
    if (line_in === 1'b0)
    begin
      got = '1;
      repeat (BIT_CLKS / 2) @(posedge clk);
      for (int k = 0; k < cap_len; k++)
      begin
        repeat (BIT_CLKS) @(posedge clk);
        got[k] = line_in;
      end
      got_cnt++;
    end
  end
endmodule // serial_node_model

// ### testbench/serial_datapath_tb_top.sv
// self-checking bench for the serial datapath
`timescale 1ns/1ps
module serial_datapath_tb_top
  import serial_pkg::*;
;
  logic       clk;
  logic       reset_n;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_write;
  logic       reg_read;
  logic [7:0] reg_rdata;
  logic       ack;
  logic       tx_empty_irq;
  logic       tx_done_irq;
  logic       rxd;
  logic       txd_out;
  logic       txd_oe;
  logic       rxd_owned;
  logic       line;
  logic       sync_transfer_clock;
  logic [3:0] cap_len;
  logic [7:0] td [4] = '{8'ha5, 8'h3c, 8'h81, 8'h7e};
  int         fails;
  int         n_tests;
  int         cycles;
  // released pin falls back to a pulled-up port
  assign line = txd_oe ? txd_out : 1'b1;
  serial_datapath #(.DEPTH(RX_DEPTH)) dut_u (
    .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .tx_done_irq_ack(ack),
    .tx_empty_irq(tx_empty_irq), .tx_done_irq(tx_done_irq),
    .rxd_pin(rxd), .xck_pin(sync_transfer_clock), .txd_out(txd_out), .txd_oe(txd_oe),
    .rxd_owned(rxd_owned));
  serial_node_model node_u (
    .clk(clk), .line_in(line), .cap_len(cap_len), .sync_transfer_clock(sync_transfer_clock),
    .line_out(rxd));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task stop_test;
    if (fails == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 12000)
    begin
      fails++;
      stop_test();
    end
  end
  task check(input string s, input logic [11:0] seen, input logic [11:0] e);
    n_tests++;
    if (seen !== e)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", s, e, seen);
    end
  endtask
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask
  task rc(input logic [2:0] a, input logic [7:0] e, input string s);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 check(s, 12'(reg_rdata), 12'(e));
  endtask
  task wait_frames(input int n);
    for (int i = 0; i < 2000 && node_u.got_cnt < n; i++)
      @(posedge clk);
    check("frame count", 12'(node_u.got_cnt), 12'(n));
  endtask
  function automatic logic [11:0] frame(input logic [8:0] d, input int nb,
                                        input logic pe, input logic odd);
    logic [11:0] f;
    logic        p;
    f = '1;
    p = odd;
    for (int i = 0; i < nb; i++)
    begin
      f[i] = d[i];
      p    = p ^ d[i];
    end
    if (pe)
      f[nb] = p;
    return f;
  endfunction
  initial
  begin
    reset_n = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
    ack = 1'b0;
    cap_len = 4'ha;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    rc(ADDR_CSA, 8'h20, "csa reset");
    rc(ADDR_CSB, CSB_RESET, "csb reset");
    rc(ADDR_CSC, CSC_RESET, "csc reset");
    rc(3'h7, 8'h00, "unmapped");
    wr(ADDR_CSB, 8'h78);
    #1 check("empty req", 12'(tx_empty_irq), 12'h001);
    check("rx owner", 12'(rxd_owned), 12'h001);
    for (int m = 0; m < 2; m++)
    begin
      wr(ADDR_CSC, m ? 8'h36 : 8'h26);
      wr(ADDR_DATA, td[2*m]);
      wr(ADDR_DATA, td[2*m+1]);
      #1 check("buffer held", 12'(tx_empty_irq), 12'h000);
      rc(ADDR_CSA, 8'h00, "csa busy");
      wait_frames(2*m+1);
      check("frame a", node_u.got, frame(td[2*m], 8, 1, m[0]));
      check("done early", 12'(tx_done_irq), 12'h000);
      wait_frames(2*m+2);
      check("frame b", node_u.got, frame(td[2*m+1], 8, 1, m[0]));
      repeat (12) @(posedge clk);
      #1 check("done req", 12'(tx_done_irq), 12'h001);
      if (m == 0)
        wr(ADDR_CSA, 8'h40);
      else
      begin
        @(posedge clk);
        ack <= 1'b1;
        @(posedge clk);
        ack <= 1'b0;
      end
      #1 check("done clear", 12'(tx_done_irq), 12'h000);
    end
    wr(ADDR_DATA, 8'h55);
    wr(ADDR_DATA, 8'h0f);
    wr(ADDR_CSB, 8'h70);
    #1 check("oe held", 12'(txd_oe), 12'h001);
    wait_frames(6);
    check("last frame", node_u.got, frame(9'h00f, 8, 1, 1'b1));
    repeat (24) @(posedge clk);
    #1 check("oe off", 12'(txd_oe), 12'h000);
    wr(ADDR_DATA, 8'h12);
    repeat (200) @(posedge clk);
    check("ignored", 12'(node_u.got_cnt), 12'h006);
    wr(ADDR_CSA, 8'h40);
    // two stops set, frames sent with one: receiver must not wait
    wr(ADDR_CSC, 8'h3e);
    node_u.send(frame(9'h081, 8, 1, 1'b1) ^ 12'h100, 10);
    node_u.send(frame(9'h042, 8, 1, 1'b1), 10);
    repeat (20) @(posedge clk);
    rc(ADDR_CSA, 8'ha4, "csa parity");
    rc(ADDR_DATA, 8'h81, "rx a");
    rc(ADDR_CSA, 8'ha0, "csa next");
    rc(ADDR_DATA, 8'h42, "rx b");
    // stale head flags stay visible once the fifo drains
    rc(ADDR_CSA, 8'h24, "csa drained");
    wr(ADDR_CSC, 8'h06);
    wr(ADDR_CSB, 8'h7d);
    wr(ADDR_DATA, 8'h5a);
    wait_frames(7);
    check("tx nine", node_u.got, frame(9'h15a, 9, 1'b0, 1'b0));
    node_u.send(frame(9'h1c3, 9, 1'b0, 1'b0), 10);
    repeat (20) @(posedge clk);
    rc(ADDR_CSA, 8'he0, "csa nine");
    rc(ADDR_CSB, 8'h7f, "rx ninth");
    rc(ADDR_DATA, 8'hc3, "rx nine");
    wr(ADDR_CSB, 8'h78);
    wr(ADDR_CSC, 8'h04);
    node_u.send(frame(9'h0ff, 7, 1'b0, 1'b0), 8);
    repeat (20) @(posedge clk);
    rc(ADDR_DATA, 8'h7f, "rx seven");
    // synchronous mode: the node's transfer clock paces the receiver
    wr(ADDR_CSC, 8'h46);
    node_u.send(frame(9'h0a5, 8, 1'b0, 1'b0), 9);
    repeat (20) @(posedge clk);
    rc(ADDR_DATA, 8'ha5, "rx sync");
    wr(ADDR_CSB, 8'h00);
    #1 check("rx release", 12'(rxd_owned), 12'h000);
    stop_test();
  end
endmodule // serial_datapath_tb_top
